// ### include/pps_params.svh
// Register offsets, field positions, reset values and fixed pin positions of the pin sharing block
`ifndef PPS_PARAMS_SVH
`define PPS_PARAMS_SVH
// Register offsets
`define PPS_OFF_DATA_A 8'h00
`define PPS_OFF_DATA_B 8'h01
`define PPS_OFF_DIR_A 8'h04
`define PPS_OFF_DIR_B 8'h05
`define PPS_OFF_PUE_A 8'h0D
`define PPS_OFF_KWE 8'h10
`define PPS_OFF_TME 8'h11
`define PPS_OFF_OPT 8'h12
`define PPS_OFF_ADC 8'h13
// Option register fields
`define PPS_OPT_OSC_LSB 0
`define PPS_OPT_OSC_MSB 1
`define PPS_OPT_SCI_BIT 2
// Reset values
`define PPS_RST_PORT 8'h00
`define PPS_RST_OPT 8'h00
// Fixed pin positions on the second port
`define PPS_B_OSC_OUT 7
`define PPS_B_OSC_IN 6
`define PPS_B_SCI_TX 5
`define PPS_B_SCI_RX 4
`endif

// ### include/pps_pkg.sv
// Types shared by the pin sharing block
package pps_pkg;
   // Oscillator pin option; code 3 behaves as internal
   typedef enum logic [1:0] {
      PPS_OSC_INTERNAL = 2'h0,
      PPS_OSC_EXTCLK = 2'h1,
      PPS_OSC_CRYSTAL = 2'h2,
      PPS_OSC_SPARE = 2'h3
   } pps_osc_type;
   // Register file state
   typedef struct packed {
      logic [4:0] data_a;
      logic [7:0] data_b;
      logic [4:0] dir_a;
      logic [7:0] dir_b;
      logic [4:0] pue_a;
      logic [4:0] kwe;
      logic [4:0] tme;
      pps_osc_type osc;
      logic sci_en;
      logic [3:0] adc_en;
      logic [7:0] rdata;
   } pps_regs_type;
   // Registered outputs of the top module
   typedef struct packed {
      logic [4:0] pa_out;
      logic [4:0] pa_oe_n;
      logic [4:0] pa_pu;
      logic [7:0] pb_out;
      logic [7:0] pb_oe_n;
      logic [4:0] key_wakeup_interrupt;
      logic [4:0] tim_in;
      logic osc_clk;
      logic osc_xtal;
      logic osc_ext;
      logic sci_rx;
      logic [3:0] adc_conn;
   } pps_top_type;
endpackage : pps_pkg

// ### include/pps_cfg_if.sv
// Configuration and pin readback carried between the register file and the pin logic
`timescale 1ns/100ps
interface pps_cfg_if;
   logic [4:0] data_a;
   logic [7:0] data_b;
   logic [4:0] dir_a;
   logic [7:0] dir_b;
   logic [4:0] pue_a;
   logic [4:0] kwe;
   logic [4:0] tme;
   pps_pkg::pps_osc_type osc;
   logic sci_en;
   logic [3:0] adc_en;
   logic [4:0] pin_a;
   logic [7:0] pin_b;
   modport regs (output data_a, data_b, dir_a, dir_b, pue_a, kwe, tme, osc, sci_en, adc_en,
      input pin_a, pin_b);
   modport core (input data_a, data_b, dir_a, dir_b, pue_a, kwe, tme, osc, sci_en, adc_en,
      output pin_a, pin_b);
   modport pull (input dir_a, pue_a, kwe, tme);
endinterface : pps_cfg_if

// ### verilog/pps_pull.sv
// Pull-up selection for the first port, one cell per pin
`timescale 1ns/100ps
module pps_pull (
   pps_cfg_if.pull cfg, // Pin configuration
   output logic [4:0] pu_o // Pull-up wanted, per pin
);
   // ************************************
   // Per-pin pull-up decision
   // ************************************
   genvar i;
   generate
      for (i = 0; i < 5; i++) begin : g_pin
         // Timer wins over everything, then key wakeup, then the software input pull-up
         assign pu_o[i] = !cfg.tme[i] && (cfg.kwe[i] || (cfg.pue_a[i] && !cfg.dir_a[i]));
      end
   endgenerate
endmodule : pps_pull

// ### verilog/pps_regs.sv
// Register file of the pin sharing block with its plain software port
`timescale 1ns/100ps
`include "pps_params.svh"
module pps_regs (
   input wire logic clock_i, // System clock
   input wire logic rst_n_i, // Asynchronous reset, active low
   input wire logic [7:0] addr_i, // Register address
   input wire logic [7:0] wdata_i, // Write data
   input wire logic wr_i, // Write strobe
   input wire logic rd_i, // Read strobe
   output logic [7:0] rdata_o, // Read data, cycle after the strobe
   pps_cfg_if.regs cfg // Configuration out, pins in
);
   pps_pkg::pps_regs_type r;
   pps_pkg::pps_regs_type next_r;

   // ************************************
   // Write decode and read mux
   // ************************************
   always_comb begin
      next_r = r;
      next_r.rdata = 8'h00;
      if (wr_i) begin
         case (addr_i)
            `PPS_OFF_DATA_A: next_r.data_a = wdata_i[4:0];
            `PPS_OFF_DATA_B: next_r.data_b = wdata_i;
            `PPS_OFF_DIR_A: next_r.dir_a = wdata_i[4:0];
            `PPS_OFF_DIR_B: next_r.dir_b = wdata_i;
            `PPS_OFF_PUE_A: next_r.pue_a = wdata_i[4:0];
            `PPS_OFF_KWE: next_r.kwe = wdata_i[4:0];
            `PPS_OFF_TME: next_r.tme = wdata_i[4:0];
            `PPS_OFF_OPT: begin
               next_r.osc = pps_pkg::pps_osc_type'(wdata_i[`PPS_OPT_OSC_MSB:`PPS_OPT_OSC_LSB]);
               next_r.sci_en = wdata_i[`PPS_OPT_SCI_BIT];
            end
            `PPS_OFF_ADC: next_r.adc_en = wdata_i[3:0];
            default: ;
         endcase
      end
      // Data reads show the latch for outputs and the pin for inputs
      if (rd_i) begin
         case (addr_i)
            `PPS_OFF_DATA_A: next_r.rdata = {3'h0, (r.dir_a & r.data_a) | (~r.dir_a & cfg.pin_a)};
            `PPS_OFF_DATA_B: next_r.rdata = (r.dir_b & r.data_b) | (~r.dir_b & cfg.pin_b);
            `PPS_OFF_DIR_A: next_r.rdata = {3'h0, r.dir_a};
            `PPS_OFF_DIR_B: next_r.rdata = r.dir_b;
            `PPS_OFF_PUE_A: next_r.rdata = {3'h0, r.pue_a};
            `PPS_OFF_KWE: next_r.rdata = {3'h0, r.kwe};
            `PPS_OFF_TME: next_r.rdata = {3'h0, r.tme};
            `PPS_OFF_OPT: next_r.rdata = {5'h00, r.sci_en, r.osc};
            `PPS_OFF_ADC: next_r.rdata = {4'h0, r.adc_en};
            default: next_r.rdata = 8'h00;
         endcase
      end
   end

   // ************************************
   // State register
   // ************************************
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign rdata_o = r.rdata;
   assign cfg.data_a = r.data_a;
   assign cfg.data_b = r.data_b;
   assign cfg.dir_a = r.dir_a;
   assign cfg.dir_b = r.dir_b;
   assign cfg.pue_a = r.pue_a;
   assign cfg.kwe = r.kwe;
   assign cfg.tme = r.tme;
   assign cfg.osc = r.osc;
   assign cfg.sci_en = r.sci_en;
   assign cfg.adc_en = r.adc_en;
endmodule : pps_regs

// ### verilog/pps_top.sv
// Pin function sharing for the two general-purpose ports and pull-up control for the first port
`timescale 1ns/100ps
`include "pps_params.svh"
module pps_top (
   input wire logic clock_i, // System clock, 100 MHz
   input wire logic rst_n_i, // Asynchronous reset, active low
   input wire logic [7:0] addr_i, // Register address
   input wire logic [7:0] wdata_i, // Register write data
   input wire logic wr_i, // Register write strobe
   input wire logic rd_i, // Register read strobe
   output logic [7:0] rdata_o, // Register read data
   input wire logic [4:0] pa_in_i, // First port pin levels
   output logic [4:0] pa_out_o, // First port pin drive values
   output logic [4:0] pa_oe_n_o, // First port drive enables, low drives
   output logic [4:0] pa_pu_o, // First port pull-up enables
   input wire logic [7:0] pb_in_i, // Second port pin levels
   output logic [7:0] pb_out_o, // Second port pin drive values
   output logic [7:0] pb_oe_n_o, // Second port drive enables, low drives
   output logic [4:0] kbi_o, // Key wakeup inputs, idle high
   input wire logic [4:0] tim_out_i, // Timer output levels per pin
   input wire logic [4:0] tim_oe_i, // Timer drives the pin
   output logic [4:0] tim_in_o, // Timer capture inputs
   output logic osc_clk_o, // Oscillator input pin level
   output logic osc_xtal_o, // Crystal option connected
   output logic osc_ext_o, // External clock option connected
   input wire logic sci_tx_i, // Serial transmit data
   output logic sci_rx_o, // Serial receive data, idle high
   output logic [3:0] adc_conn_o // Converter channel connected to pin
);
   pps_pkg::pps_top_type s;
   pps_pkg::pps_top_type next_s;
   pps_cfg_if cfg ();
   logic [4:0] pull;
   logic xtal_sel;
   logic ext_sel;

   // ************************************
   // Register file and pull-up cells
   // ************************************
   pps_regs pps_regs_inst (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .addr_i(addr_i),
      .wdata_i(wdata_i),
      .wr_i(wr_i),
      .rd_i(rd_i),
      .rdata_o(rdata_o),
      .cfg(cfg.regs)
   );

   pps_pull pps_pull_inst (
      .cfg(cfg.pull),
      .pu_o(pull)
   );

   // Pin levels back to the register file for data reads
   assign cfg.pin_a = pa_in_i;
   assign cfg.pin_b = pb_in_i;

   // Oscillator option decode
   assign xtal_sel = (cfg.osc == pps_pkg::PPS_OSC_CRYSTAL);
   assign ext_sel = (cfg.osc == pps_pkg::PPS_OSC_EXTCLK);

   // ************************************
   // Pin routing
   // ************************************
   always_comb begin
      next_s = s;
      // First port: timer over key wakeup over general I/O
      for (int i = 0; i < 5; i++) begin
         if (cfg.tme[i]) begin
            next_s.pa_out[i] = tim_out_i[i];
            next_s.pa_oe_n[i] = !tim_oe_i[i];
         end else if (cfg.kwe[i]) begin
            next_s.pa_out[i] = cfg.data_a[i];
            next_s.pa_oe_n[i] = 1'b1;
         end else begin
            next_s.pa_out[i] = cfg.data_a[i];
            next_s.pa_oe_n[i] = !cfg.dir_a[i];
         end
         next_s.key_wakeup_interrupt[i] = cfg.kwe[i] ? pa_in_i[i] : 1'b1;
         next_s.tim_in[i] = cfg.tme[i] ? pa_in_i[i] : 1'b0;
      end
      next_s.pa_pu = pull;
      // Second port: general I/O by default
      for (int j = 0; j < 8; j++) begin
         next_s.pb_out[j] = cfg.data_b[j];
         next_s.pb_oe_n[j] = !cfg.dir_b[j];
      end
      // Converter channels release their pins
      for (int k = 0; k < 4; k++) begin
         next_s.adc_conn[k] = cfg.adc_en[k];
         if (cfg.adc_en[k]) begin
            next_s.pb_oe_n[k] = 1'b1;
         end
      end
      // Serial interface takes transmit and receive pins
      next_s.sci_rx = cfg.sci_en ? pb_in_i[`PPS_B_SCI_RX] : 1'b1;
      if (cfg.sci_en) begin
         next_s.pb_out[`PPS_B_SCI_TX] = sci_tx_i;
         next_s.pb_oe_n[`PPS_B_SCI_TX] = 1'b0;
         next_s.pb_oe_n[`PPS_B_SCI_RX] = 1'b1;
      end
      // Oscillator option takes one or two pins
      next_s.osc_xtal = xtal_sel;
      next_s.osc_ext = ext_sel;
      next_s.osc_clk = (xtal_sel || ext_sel) ? pb_in_i[`PPS_B_OSC_IN] : 1'b0;
      if (xtal_sel || ext_sel) begin
         next_s.pb_oe_n[`PPS_B_OSC_IN] = 1'b1;
         next_s.pb_out[`PPS_B_OSC_IN] = 1'b0;
      end
      if (xtal_sel) begin
         next_s.pb_oe_n[`PPS_B_OSC_OUT] = 1'b1;
         next_s.pb_out[`PPS_B_OSC_OUT] = 1'b0;
      end
   end

   // ************************************
   // Output register
   // ************************************
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s.pa_out <= 5'h00;
         s.pa_oe_n <= 5'h1F;
         s.pa_pu <= 5'h00;
         s.pb_out <= 8'h00;
         s.pb_oe_n <= 8'hFF;
         s.key_wakeup_interrupt <= 5'h1F;
         s.tim_in <= 5'h00;
         s.osc_clk <= 1'b0;
         s.osc_xtal <= 1'b0;
         s.osc_ext <= 1'b0;
         s.sci_rx <= 1'b1;
         s.adc_conn <= 4'h0;
      end else begin
         s <= next_s;
      end
   end

   assign pa_out_o = s.pa_out;
   assign pa_oe_n_o = s.pa_oe_n;
   assign pa_pu_o = s.pa_pu;
   assign pb_out_o = s.pb_out;
   assign pb_oe_n_o = s.pb_oe_n;
   assign kbi_o = s.key_wakeup_interrupt;
   assign tim_in_o = s.tim_in;
   assign osc_clk_o = s.osc_clk;
   assign osc_xtal_o = s.osc_xtal;
   assign osc_ext_o = s.osc_ext;
   assign sci_rx_o = s.sci_rx;
   assign adc_conn_o = s.adc_conn;

   // ************************************
   // Assertions
   // ************************************
   // Key wakeup pin with no timer has its pull-up one cycle later
   property p_kw_pull;
      @(posedge clock_i) disable iff (!rst_n_i)
      (cfg.kwe[0] && !cfg.tme[0]) |=> pa_pu_o[0];
   endproperty
   a_kw_pull: assert property (p_kw_pull) else $error("key wakeup pin lacks pull-up");

   // Timer pin never shows a pull-up
   property p_tim_nopull;
      @(posedge clock_i) disable iff (!rst_n_i)
      cfg.tme != 5'h00 |=> (pa_pu_o & $past(cfg.tme)) == 5'h00;
   endproperty
   a_tim_nopull: assert property (p_tim_nopull) else $error("pull-up on timer pin");

   // Software pull-up follows enable on plain inputs
   property p_sw_pull;
      @(posedge clock_i) disable iff (!rst_n_i)
      (cfg.tme[1] == 1'b0 && cfg.kwe[1] == 1'b0 && cfg.dir_a[1] == 1'b0)
         |=> pa_pu_o[1] == $past(cfg.pue_a[1]);
   endproperty
   a_sw_pull: assert property (p_sw_pull) else $error("input pull-up not software");

   // Key wakeup input follows the pin level
   property p_kbi_path;
      @(posedge clock_i) disable iff (!rst_n_i)
      cfg.kwe[2] |=> kbi_o[2] == $past(pa_in_i[2]);
   endproperty
   a_kbi_path: assert property (p_kbi_path) else $error("key wakeup input wrong");

   // Timer drives its pin when it asks to
   property p_tim_drive;
      @(posedge clock_i) disable iff (!rst_n_i)
      (cfg.tme[2] && tim_oe_i[2]) |=> (!pa_oe_n_o[2] && pa_out_o[2] == $past(tim_out_i[2]));
   endproperty
   a_tim_drive: assert property (p_tim_drive) else $error("timer does not drive pin");

   // Crystal releases both oscillator pins
   property p_xtal_pins;
      @(posedge clock_i) disable iff (!rst_n_i)
      xtal_sel |=> (pb_oe_n_o[7] && pb_oe_n_o[6] && osc_xtal_o);
   endproperty
   a_xtal_pins: assert property (p_xtal_pins) else $error("crystal pins still driven");

   // External clock keeps bit seven as general I/O
   property p_ext_pins;
      @(posedge clock_i) disable iff (!rst_n_i)
      ext_sel |=> (pb_oe_n_o[6] && pb_oe_n_o[7] == !$past(cfg.dir_b[7]));
   endproperty
   a_ext_pins: assert property (p_ext_pins) else $error("external clock pin use wrong");

   // Without an oscillator option the clock path stays quiet
   property p_osc_off;
      @(posedge clock_i) disable iff (!rst_n_i)
      (!xtal_sel && !ext_sel) ##1 (!xtal_sel && !ext_sel) |-> (!osc_clk_o && !osc_xtal_o);
   endproperty
   a_osc_off: assert property (p_osc_off) else $error("oscillator connected without option");

   // Serial interface owns transmit and receive pins
   property p_sci_pins;
      @(posedge clock_i) disable iff (!rst_n_i)
      cfg.sci_en |=> (!pb_oe_n_o[5] && pb_out_o[5] == $past(sci_tx_i)
         && pb_oe_n_o[4] && sci_rx_o == $past(pb_in_i[4]));
   endproperty
   a_sci_pins: assert property (p_sci_pins) else $error("serial pins not handed over");

   // Converter channel releases its pin
   property p_adc_pin;
      @(posedge clock_i) disable iff (!rst_n_i)
      cfg.adc_en[0] |=> (pb_oe_n_o[0] && adc_conn_o[0]);
   endproperty
   a_adc_pin: assert property (p_adc_pin) else $error("converter pin still driven");

   // Plain second-port pin follows data and direction
   property p_gpio_b;
      @(posedge clock_i) disable iff (!rst_n_i)
      !cfg.adc_en[2] |=> (pb_out_o[2] == $past(cfg.data_b[2])
         && pb_oe_n_o[2] == !$past(cfg.dir_b[2]));
   endproperty
   a_gpio_b: assert property (p_gpio_b) else $error("general I/O not restored");

   // Key wakeup pin with no timer is never driven
   property p_kw_input;
      @(posedge clock_i) disable iff (!rst_n_i)
      (cfg.kwe[0] && !cfg.tme[0]) |=> pa_oe_n_o[0];
   endproperty
   a_kw_input: assert property (p_kw_input) else $error("wakeup pin driven");

   // Key wakeup input idles high while disabled
   property p_kbi_idle;
      @(posedge clock_i) disable iff (!rst_n_i)
      !cfg.kwe[4] |=> kbi_o[4];
   endproperty
   a_kbi_idle: assert property (p_kbi_idle) else $error("idle key wakeup input low");

   // Timer capture input follows the pin
   property p_tim_in;
      @(posedge clock_i) disable iff (!rst_n_i)
      cfg.tme[1] |=> tim_in_o[1] == $past(pa_in_i[1]);
   endproperty
   a_tim_in: assert property (p_tim_in) else $error("timer capture input wrong");

   // Timer capture input stays low while disabled
   property p_tim_in_idle;
      @(posedge clock_i) disable iff (!rst_n_i)
      !cfg.tme[0] |=> !tim_in_o[0];
   endproperty
   a_tim_in_idle: assert property (p_tim_in_idle) else $error("timer input not low");

   // Timer pin not asked to drive is released
   property p_tim_release;
      @(posedge clock_i) disable iff (!rst_n_i)
      (cfg.tme[1] && !tim_oe_i[1]) |=> pa_oe_n_o[1];
   endproperty
   a_tim_release: assert property (p_tim_release) else $error("idle timer pin driven");

   // Plain first-port pin follows data and direction
   property p_gpio_a;
      @(posedge clock_i) disable iff (!rst_n_i)
      (!cfg.tme[4] && !cfg.kwe[4]) |=> (pa_out_o[4] == $past(cfg.data_a[4])
         && pa_oe_n_o[4] == !$past(cfg.dir_a[4]));
   endproperty
   a_gpio_a: assert property (p_gpio_a) else $error("first port I/O wrong");

   // Output pin without key wakeup has no pull-up
   property p_out_nopull;
      @(posedge clock_i) disable iff (!rst_n_i)
      (!cfg.kwe[3] && cfg.dir_a[3]) |=> !pa_pu_o[3];
   endproperty
   a_out_nopull: assert property (p_out_nopull) else $error("pull-up on output pin");

   // Oscillator input level reaches the clock circuit
   property p_osc_clk;
      @(posedge clock_i) disable iff (!rst_n_i)
      (xtal_sel || ext_sel) |=> osc_clk_o == $past(pb_in_i[`PPS_B_OSC_IN]);
   endproperty
   a_osc_clk: assert property (p_osc_clk) else $error("oscillator input lost");

   // External clock option flags itself only
   property p_ext_flag;
      @(posedge clock_i) disable iff (!rst_n_i)
      ext_sel |=> (osc_ext_o && !osc_xtal_o);
   endproperty
   a_ext_flag: assert property (p_ext_flag) else $error("external clock flag wrong");

   // Serial receive idles high while disabled
   property p_rx_idle;
      @(posedge clock_i) disable iff (!rst_n_i)
      !cfg.sci_en |=> sci_rx_o;
   endproperty
   a_rx_idle: assert property (p_rx_idle) else $error("serial receive not idle");

   // Transmit pin is general I/O without the serial interface
   property p_tx_gpio;
      @(posedge clock_i) disable iff (!rst_n_i)
      !cfg.sci_en |=> (pb_out_o[5] == $past(cfg.data_b[5])
         && pb_oe_n_o[5] == !$past(cfg.dir_b[5]));
   endproperty
   a_tx_gpio: assert property (p_tx_gpio) else $error("transmit pin not I/O");

   // Disabled converter channel is not connected
   property p_adc_idle;
      @(posedge clock_i) disable iff (!rst_n_i)
      !cfg.adc_en[3] |=> !adc_conn_o[3];
   endproperty
   a_adc_idle: assert property (p_adc_idle) else $error("idle channel connected");

   // Without crystal, bit seven stays general I/O
   property p_b7_gpio;
      @(posedge clock_i) disable iff (!rst_n_i)
      !xtal_sel |=> (pb_out_o[7] == $past(cfg.data_b[7])
         && pb_oe_n_o[7] == !$past(cfg.dir_b[7]));
   endproperty
   a_b7_gpio: assert property (p_b7_gpio) else $error("bit seven not I/O");

   // Scenarios
   c_kw_pull: cover property (@(posedge clock_i) disable iff (!rst_n_i)
      cfg.kwe[0] ##1 pa_pu_o[0]);
   c_xtal: cover property (@(posedge clock_i) disable iff (!rst_n_i) xtal_sel ##1 osc_xtal_o);
   c_sci: cover property (@(posedge clock_i) disable iff (!rst_n_i) cfg.sci_en ##1 !sci_rx_o);
   c_tim: cover property (@(posedge clock_i) disable iff (!rst_n_i)
      (cfg.tme[2] && tim_oe_i[2]) ##1 !pa_oe_n_o[2]);
   c_ext: cover property (@(posedge clock_i) disable iff (!rst_n_i) ext_sel ##1 osc_ext_o);
endmodule : pps_top

// ### verif/tb_pps_top.sv
// Self-checking testbench of the pin function sharing block
`timescale 1ns/100ps
`include "pps_params.svh"
`define PPS_CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
   $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb_pps_top;
   // ********************************
   // Signals, rows and design instance
   // ********************************
   typedef struct packed {
      logic [4:0] dir_a, dat_a, pue, kwe, tme, toe, tout, pin_a;
      logic [7:0] dir_b, dat_b, opt, adc, pin_b;
      logic tx;
      logic [4:0] e_pu, e_oea, e_outa, e_kbi, e_tin;
      logic [7:0] e_oeb, e_outb;
      logic [2:0] e_osc;
      logic e_rx;
      logic [3:0] e_adc;
   } pps_row_type;
   logic clock, rst_n, wr, rd, sci_tx, osc_clk, osc_xtal, osc_ext, sci_rx;
   logic [7:0] addr, wdata, rdata, pb_in, pb_out, pb_oe_n;
   logic [4:0] pa_in, pa_out, pa_oe_n, pa_pu, key_wakeup_interrupt, tim_out, tim_oe, tim_in;
   logic [3:0] adc_conn;
   int num_errors = 0;
   int checks_done = 0;
   // Configuration and pins beside the outputs they should give
   pps_row_type rows [6] = '{
      '{5'h03, 5'h01, 5'h1C, 5'h00, 5'h00, 5'h00, 5'h00, 5'h15, 8'hFF, 8'hA5, 8'h00, 8'h00, 8'h40,
        1'h0, 5'h1C, 5'h1C, 5'h01, 5'h1F, 5'h00, 8'h00, 8'hA5, 3'h0, 1'h1, 4'h0},
      '{5'h00, 5'h00, 5'h00, 5'h0A, 5'h00, 5'h00, 5'h00, 5'h08, 8'hFF, 8'hFF, 8'h01, 8'h00, 8'h40,
        1'h0, 5'h0A, 5'h1F, 5'h00, 5'h1D, 5'h00, 8'h40, 8'hBF, 3'h5, 1'h1, 4'h0},
      '{5'h00, 5'h00, 5'h1F, 5'h00, 5'h06, 5'h04, 5'h04, 5'h02, 8'hFF, 8'hFF, 8'h02, 8'h00, 8'h40,
        1'h0, 5'h19, 5'h1B, 5'h04, 5'h1F, 5'h02, 8'hC0, 8'h3F, 3'h6, 1'h1, 4'h0},
      '{5'h18, 5'h10, 5'h1F, 5'h01, 5'h00, 5'h00, 5'h00, 5'h00, 8'hFF, 8'hFF, 8'h03, 8'h00, 8'h40,
        1'h0, 5'h07, 5'h07, 5'h10, 5'h1E, 5'h00, 8'h00, 8'hFF, 3'h0, 1'h1, 4'h0},
      '{5'h03, 5'h01, 5'h1C, 5'h00, 5'h00, 5'h00, 5'h00, 5'h15, 8'hFF, 8'h00, 8'h04, 8'h0F, 8'h00,
        1'h1, 5'h1C, 5'h1C, 5'h01, 5'h1F, 5'h00, 8'h1F, 8'h20, 3'h0, 1'h0, 4'hF},
      '{5'h00, 5'h00, 5'h00, 5'h0A, 5'h00, 5'h00, 5'h00, 5'h08, 8'h00, 8'h00, 8'h04, 8'h05, 8'h10,
        1'h0, 5'h0A, 5'h1F, 5'h00, 5'h1D, 5'h00, 8'hDF, 8'h00, 3'h0, 1'h1, 4'h5}};
   logic [7:0] reg_list [10] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h0D, 8'h10, 8'h11, 8'h12, 8'h13,
      8'h02};

   pps_top pps_top_inst (
      .clock_i(clock), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .pa_in_i(pa_in), .pa_out_o(pa_out), .pa_oe_n_o(pa_oe_n),
      .pa_pu_o(pa_pu), .pb_in_i(pb_in), .pb_out_o(pb_out), .pb_oe_n_o(pb_oe_n), .kbi_o(key_wakeup_interrupt),
      .tim_out_i(tim_out), .tim_oe_i(tim_oe), .tim_in_o(tim_in), .osc_clk_o(osc_clk),
      .osc_xtal_o(osc_xtal), .osc_ext_o(osc_ext), .sci_tx_i(sci_tx), .sci_rx_o(sci_rx),
      .adc_conn_o(adc_conn));

   // ********************************
   // Bus cycles and checks
   // ********************************
   // One-cycle write strobe
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wr_reg
   // One-cycle read strobe, data looked at in the following cycle only
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      `PPS_CHK(nm, e, rdata)
   endtask : rd_chk
   // Pin outputs reflect a write one edge after the write edge
   task automatic settle;
      repeat (2) @(posedge clock);
      #1;
   endtask : settle
   task automatic chk_reset;
      `PPS_CHK("pa_oe_n", 5'h1F, pa_oe_n)
      `PPS_CHK("pb_oe_n", 8'hFF, pb_oe_n)
      `PPS_CHK("pa_pu", 5'h00, pa_pu)
      `PPS_CHK("kbi", 5'h1F, key_wakeup_interrupt)
      `PPS_CHK("osc_rx_adc", 8'h10, {osc_clk, osc_xtal, osc_ext, sci_rx, adc_conn})
   endtask : chk_reset
   task automatic apply(input pps_row_type r);
      @(posedge clock);
      pa_in <= r.pin_a;
      pb_in <= r.pin_b;
      tim_out <= r.tout;
      tim_oe <= r.toe;
      sci_tx <= r.tx;
      wr_reg(`PPS_OFF_DATA_A, {3'h0, r.dat_a});
      wr_reg(`PPS_OFF_DATA_B, r.dat_b);
      wr_reg(`PPS_OFF_DIR_A, {3'h0, r.dir_a});
      wr_reg(`PPS_OFF_DIR_B, r.dir_b);
      wr_reg(`PPS_OFF_PUE_A, {3'h0, r.pue});
      wr_reg(`PPS_OFF_KWE, {3'h0, r.kwe});
      wr_reg(`PPS_OFF_TME, {3'h0, r.tme});
      wr_reg(`PPS_OFF_OPT, r.opt);
      wr_reg(`PPS_OFF_ADC, r.adc);
      settle();
   endtask : apply
   task automatic chk_row(input pps_row_type r);
      `PPS_CHK("pa_pu", r.e_pu, pa_pu)
      `PPS_CHK("pa_oe_n", r.e_oea, pa_oe_n)
      `PPS_CHK("pa_out", r.e_outa, pa_out & ~pa_oe_n)
      `PPS_CHK("kbi", r.e_kbi, key_wakeup_interrupt)
      `PPS_CHK("tim_in", r.e_tin, tim_in)
      `PPS_CHK("pb_oe_n", r.e_oeb, pb_oe_n)
      `PPS_CHK("pb_out", r.e_outb, pb_out & ~pb_oe_n)
      `PPS_CHK("osc", r.e_osc, {osc_clk, osc_xtal, osc_ext})
      `PPS_CHK("sci_rx", r.e_rx, sci_rx)
      `PPS_CHK("adc_conn", r.e_adc, adc_conn)
      rd_chk(`PPS_OFF_DATA_A, {3'h0, (r.dat_a & r.dir_a) | (r.pin_a & ~r.dir_a)}, "data_a");
      rd_chk(`PPS_OFF_KWE, {3'h0, r.kwe}, "kwe");
   endtask : chk_row
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : stop_test

   // ********************************
   // Clock, watchdog and main sequence
   // ********************************
   // Free running 100 MHz clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Cuts a hang short
   initial begin
      repeat (20000) @(posedge clock);
      num_errors++;
      $display("ERROR watchdog ran out");
      stop_test();
   end
   // Reset, timing cases, table of rows, then the awkward cases and a second reset
   initial begin
      rst_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      pa_in = 5'h00;
      pb_in = 8'h00;
      tim_out = 5'h00;
      tim_oe = 5'h00;
      sci_tx = 1'b1;
      repeat (3) @(posedge clock);
      #1;
      chk_reset();
      rst_n <= 1'b1;
      foreach (reg_list[k]) rd_chk(reg_list[k], 8'h00, "reset_reg");
      $display("test reset done");
      wr_reg(`PPS_OFF_DIR_A, 8'h01);
      #1;
      `PPS_CHK("pa_oe_n_early", 5'h1F, pa_oe_n)
      @(posedge clock);
      #1;
      `PPS_CHK("pa_oe_n_late", 5'h1E, pa_oe_n)
      wr_reg(8'h02, 8'hFF);
      rd_chk(8'h02, 8'h00, "unmapped");
      wr_reg(`PPS_OFF_OPT, 8'hFF);
      rd_chk(`PPS_OFF_OPT, 8'h07, "opt_width");
      @(posedge clock);
      #1;
      `PPS_CHK("rdata_idle", 8'h00, rdata)
      $display("test timing done");
      for (int i = 0; i < 6; i++) begin
         apply(rows[i]);
         chk_row(rows[i]);
         $display("test row %0d done", i);
      end
      wr_reg(`PPS_OFF_PUE_A, 8'h1F);
      wr_reg(`PPS_OFF_KWE, 8'h01);
      wr_reg(`PPS_OFF_TME, 8'h01);
      settle();
      `PPS_CHK("pa_pu_both", 5'h1E, pa_pu)
      wr_reg(`PPS_OFF_TME, 8'h00);
      settle();
      `PPS_CHK("pa_pu_kwe", 5'h1F, pa_pu)
      wr_reg(`PPS_OFF_KWE, 8'h00);
      wr_reg(`PPS_OFF_DIR_A, 8'h03);
      settle();
      `PPS_CHK("pa_pu_dir", 5'h1C, pa_pu)
      $display("test pull-up done");
      @(posedge clock);
      pa_in <= 5'h1F;
      wr_reg(`PPS_OFF_KWE, 8'h04);
      settle();
      `PPS_CHK("kbi_high", 5'h1F, key_wakeup_interrupt)
      @(posedge clock);
      pa_in <= 5'h00;
      @(posedge clock);
      #1;
      `PPS_CHK("kbi_low", 5'h1B, key_wakeup_interrupt)
      $display("test wakeup pin done");
      wr_reg(`PPS_OFF_DIR_B, 8'hFF);
      wr_reg(`PPS_OFF_DATA_B, 8'h5A);
      settle();
      `PPS_CHK("pb_oe_n_shared", 8'h15, pb_oe_n)
      wr_reg(`PPS_OFF_OPT, 8'h00);
      wr_reg(`PPS_OFF_ADC, 8'h00);
      settle();
      `PPS_CHK("pb_oe_n_restored", 8'h00, pb_oe_n)
      `PPS_CHK("pb_out_restored", 8'h5A, pb_out)
      rd_chk(`PPS_OFF_DATA_B, 8'h5A, "data_b");
      $display("test restore done");
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (3) @(posedge clock);
      #1;
      chk_reset();
      @(posedge clock);
      rst_n <= 1'b1;
      rd_chk(`PPS_OFF_KWE, 8'h00, "kwe_after_reset");
      $display("test second reset done");
      stop_test();
   end
endmodule : tb_pps_top
